// File: hw/ltm_params.svh
// Offsets, field positions, reset values and counts of the mode control
`ifndef LTM_PARAMS_SVH
`define LTM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define LTM_OFF_FLAGS 8'h00
`define LTM_OFF_STATUS 8'h04
`define LTM_OFF_SEG0 8'h08
`define LTM_OFF_SEG5 8'h1C

// ----------------------------------------------------------------------
// Processor flags fields
// ----------------------------------------------------------------------
`define LTM_BIT_VM 17
`define LTM_BIT_NT 14
`define LTM_IO_PRIVILEGE_LEVEL_HI 13
`define LTM_IO_PRIVILEGE_LEVEL_LO 12
`define LTM_FLAGS_RESET 32'h00000002

// ----------------------------------------------------------------------
// Status fields, privilege and counts
// ----------------------------------------------------------------------
`define LTM_ST_VM 0
`define LTM_ST_BUSY 1
`define LTM_ST_CPL_LO 2
`define LTM_ST_CPL_HI 3
`define LTM_CPL_USER 2'h3
`define LTM_CPL_SUPER 2'h0
`define LTM_NUM_SEG 6
`define LTM_LAST_SEG 3'h5
`define LTM_SEL_SHIFT 4

`endif

// File: hw/ltm_pkg.sv
// Types shared by the legacy task mode control
package ltm_pkg;

  typedef logic [2:0] ltm_seg_t;

  typedef enum logic [0:0] {
    LTM_IDLE,
    LTM_SEG
  } ltm_state_e;

  // Target task image: flags, selectors and prefetched descriptor bases
  typedef struct packed {
    logic tss32;
    logic [31:0] flags_img;
    logic [5:0][15:0] sel;
    logic [5:0][31:0] desc_base;
  } ltm_ts_s;

  // Decoder classification of the current instruction
  typedef struct packed {
    logic valid;
    logic privileged;
    logic vm_unsupported;
    logic io_privilege_level_sensitive;
  } ltm_dec_s;

  // Segment base formed from a selector, no descriptor access
  function automatic logic [31:0] ltm_legacy_base(input logic [15:0] sel);
    ltm_legacy_base = {12'h000, sel, 4'h0};
  endfunction

endpackage

// File: hw/ltm_seg_xlate.sv
// Segment base formation and linear address generation
`timescale 1ns/1ps
`include "ltm_params.svh"

module ltm_seg_xlate (
  input wire logic i_vm,
  input wire logic [15:0] i_sel,
  input wire logic [31:0] i_desc_base,
  input wire logic [31:0] i_lin_base,
  input wire logic [15:0] i_lin_off,
  output logic [31:0] o_base,
  output logic o_desc_used,
  output logic [31:0] o_linear
);

  // ----------------------------------------------------------------------
  // Base: selector shift in emulation mode, descriptor otherwise
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (i_vm)
    begin
      o_base = ltm_pkg::ltm_legacy_base(i_sel);
      o_desc_used = 1'b0;
    end
    else
    begin
      o_base = i_desc_base;
      o_desc_used = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Full 32-bit sum, no wrap at the 1 MByte edge
  // ----------------------------------------------------------------------
  assign o_linear = i_lin_base + {16'h0000, i_lin_off};

endmodule

// File: hw/ltm_priv_check.sv
// Privilege, decode and page permission checks steered by the mode flag
`timescale 1ns/1ps
`include "ltm_params.svh"

module ltm_priv_check (
  input wire logic i_vm,
  input wire logic [1:0] i_prot_cpl,
  input wire ltm_pkg::ltm_dec_s i_dec,
  input wire logic i_page_user,
  output logic [1:0] o_cpl,
  output logic o_dec_fault,
  output logic o_io_privilege_level_sens,
  output logic o_page_deny,
  output logic o_seg_prot_en
);

  // ----------------------------------------------------------------------
  // Effective privilege
  // ----------------------------------------------------------------------
  assign o_cpl = i_vm ? `LTM_CPL_USER : i_prot_cpl;

  // ----------------------------------------------------------------------
  // Decoder classification
  // ----------------------------------------------------------------------
  always_comb
  begin
    o_dec_fault = 1'b0;
    o_io_privilege_level_sens = 1'b0;
    if (i_dec.valid)
    begin
      o_dec_fault = (i_vm && i_dec.vm_unsupported) ||
                    (i_dec.privileged && o_cpl != `LTM_CPL_SUPER);
      o_io_privilege_level_sens = i_vm && i_dec.io_privilege_level_sensitive;
    end
  end

  // ----------------------------------------------------------------------
  // Page and segment protection
  // ----------------------------------------------------------------------
  assign o_page_deny = (o_cpl == `LTM_CPL_USER) && !i_page_user;
  assign o_seg_prot_en = !i_vm;

endmodule

// File: hw/ltm_mode_ctrl.sv
// Legacy emulation mode control: flags, task entry, segment bases
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "ltm_params.svh"

module ltm_mode_ctrl (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_ts_req,
  input wire logic i_interrupt_return_instr_req,
  input wire ltm_pkg::ltm_ts_s i_ts,
  input wire logic i_seg_load,
  input wire ltm_pkg::ltm_seg_t i_seg_idx,
  input wire logic [15:0] i_seg_sel,
  input wire logic [31:0] i_seg_desc_base,
  input wire logic i_addr_req,
  input wire ltm_pkg::ltm_seg_t i_addr_seg,
  input wire logic [15:0] i_addr_off,
  input wire ltm_pkg::ltm_dec_s i_dec,
  input wire logic [1:0] i_prot_cpl,
  input wire logic i_page_chk,
  input wire logic i_page_user,
  output logic o_vm_mode,
  output logic o_busy,
  output logic [31:0] o_linear_addr,
  output logic o_addr_valid,
  output logic o_desc_lookup,
  output logic [1:0] o_cpl,
  output logic o_dec_fault,
  output logic o_io_privilege_level_sens,
  output logic o_page_deny,
  output logic o_seg_prot_en
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [31:0] flags_r;
  ltm_pkg::ltm_state_e state_r;
  ltm_pkg::ltm_seg_t cnt_r;
  ltm_pkg::ltm_ts_s ts_r;
  logic [31:0] base_r [`LTM_NUM_SEG];
  logic busy_r;
  logic vm;
  logic idle;
  logic ts_go;
  logic stk_go;
  logic sw_flags_wr;
  logic [31:0] ts_flags_nxt;
  logic [3:0] rd_slot;
  logic [15:0] xl_sel;
  logic [31:0] xl_desc;
  logic [31:0] xl_base;
  logic xl_desc_used;
  logic [31:0] lin;
  logic [1:0] pc_cpl;
  logic pc_dec_fault;
  logic pc_io_privilege_level_sens;
  logic pc_page_deny;
  logic pc_seg_prot_en;

  assign vm = flags_r[`LTM_BIT_VM];
  assign idle = (state_r == ltm_pkg::LTM_IDLE);
  // Task switch: call/jump, or return with nested task flag set
  assign ts_go = idle && (i_ts_req ||
                 (i_interrupt_return_instr_req && flags_r[`LTM_BIT_NT]));
  // Return from a handler, flags image taken from the stack
  assign stk_go = idle && !i_ts_req && i_interrupt_return_instr_req &&
                  !flags_r[`LTM_BIT_NT];
  assign sw_flags_wr = idle && !i_ts_req && !i_interrupt_return_instr_req && i_reg_wr &&
                       (i_reg_addr == `LTM_OFF_FLAGS);
  // 16-bit image has no upper word, so the mode flag reads as zero
  assign ts_flags_nxt = i_ts.tss32 ? i_ts.flags_img :
                        {16'h0000, i_ts.flags_img[15:0]};

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] seg_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LTM_OFF_SEG0;
    if (a >= `LTM_OFF_SEG0 && a <= `LTM_OFF_SEG5 && d[1:0] == 2'h0)
      seg_slot = {1'b1, d[4:2]};
    else
      seg_slot = 4'h0;
  endfunction

  // ----------------------------------------------------------------------
  // Shared translation and checks
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (state_r == ltm_pkg::LTM_SEG)
    begin
      xl_sel = ts_r.sel[cnt_r];
      xl_desc = ts_r.desc_base[cnt_r];
    end
    else
    begin
      xl_sel = i_seg_sel;
      xl_desc = i_seg_desc_base;
    end
  end

  ltm_seg_xlate u_xlate (
    .i_vm(vm),
    .i_sel(xl_sel),
    .i_desc_base(xl_desc),
    .i_lin_base(base_r[i_addr_seg]),
    .i_lin_off(i_addr_off),
    .o_base(xl_base),
    .o_desc_used(xl_desc_used),
    .o_linear(lin)
  );

  ltm_priv_check u_priv (
    .i_vm(vm),
    .i_prot_cpl(i_prot_cpl),
    .i_dec(i_dec),
    .i_page_user(i_page_user),
    .o_cpl(pc_cpl),
    .o_dec_fault(pc_dec_fault),
    .o_io_privilege_level_sens(pc_io_privilege_level_sens),
    .o_page_deny(pc_page_deny),
    .o_seg_prot_en(pc_seg_prot_en)
  );

  // ----------------------------------------------------------------------
  // Processor flags
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      flags_r <= `LTM_FLAGS_RESET;
    else if (ts_go)
      flags_r <= ts_flags_nxt;
    else if (stk_go)
      flags_r <= i_ts.flags_img;
    else if (sw_flags_wr)
      flags_r <= {i_reg_wdata[31:18], flags_r[`LTM_BIT_VM],
                  i_reg_wdata[16:0]};
  end

  // ----------------------------------------------------------------------
  // Entry sequencer: flags first, then six segment loads
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= ltm_pkg::LTM_IDLE;
      cnt_r <= 3'h0;
      busy_r <= 1'b0;
      ts_r <= '0;
    end
    else
    begin
      case (state_r)
        ltm_pkg::LTM_IDLE:
        begin
          if (ts_go || stk_go)
          begin
            ts_r <= i_ts;
            cnt_r <= 3'h0;
            state_r <= ltm_pkg::LTM_SEG;
            busy_r <= 1'b1;
          end
        end
        ltm_pkg::LTM_SEG:
        begin
          if (cnt_r == `LTM_LAST_SEG)
          begin
            state_r <= ltm_pkg::LTM_IDLE;
            busy_r <= 1'b0;
          end
          else
            cnt_r <= cnt_r + 3'h1;
        end
        default:
        begin
          state_r <= ltm_pkg::LTM_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Segment bases
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < `LTM_NUM_SEG; i++)
        base_r[i] <= 32'h00000000;
      o_desc_lookup <= 1'b0;
    end
    else
    begin
      o_desc_lookup <= 1'b0;
      if (state_r == ltm_pkg::LTM_SEG)
      begin
        base_r[cnt_r] <= xl_base;
        o_desc_lookup <= xl_desc_used;
      end
      else if (i_seg_load && !i_ts_req && !i_interrupt_return_instr_req &&
               i_seg_idx < `LTM_NUM_SEG)
      begin
        base_r[i_seg_idx] <= xl_base;
        o_desc_lookup <= xl_desc_used;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_linear_addr <= 32'h00000000;
      o_addr_valid <= 1'b0;
      o_cpl <= `LTM_CPL_SUPER;
      o_dec_fault <= 1'b0;
      o_io_privilege_level_sens <= 1'b0;
      o_page_deny <= 1'b0;
      o_seg_prot_en <= 1'b1;
    end
    else
    begin
      o_addr_valid <= i_addr_req;
      if (i_addr_req)
        o_linear_addr <= lin;
      o_cpl <= pc_cpl;
      o_dec_fault <= pc_dec_fault;
      o_io_privilege_level_sens <= pc_io_privilege_level_sens;
      o_page_deny <= i_page_chk && pc_page_deny;
      o_seg_prot_en <= pc_seg_prot_en;
    end
  end

  assign o_vm_mode = flags_r[`LTM_BIT_VM];
  assign o_busy = busy_r;

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  assign rd_slot = seg_slot(i_reg_addr);

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_reg_rdata <= 32'h00000000;
    else if (!i_reg_rd)
      o_reg_rdata <= 32'h00000000;
    else if (i_reg_addr == `LTM_OFF_FLAGS)
      o_reg_rdata <= flags_r;
    else if (i_reg_addr == `LTM_OFF_STATUS)
    begin
      o_reg_rdata <= 32'h00000000;
      o_reg_rdata[`LTM_ST_VM] <= vm;
      o_reg_rdata[`LTM_ST_BUSY] <= busy_r;
      o_reg_rdata[`LTM_ST_CPL_HI:`LTM_ST_CPL_LO] <= pc_cpl;
    end
    else if (rd_slot[3])
      o_reg_rdata <= base_r[rd_slot[2:0]];
    else
      o_reg_rdata <= 32'h00000000;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  a_vm_direct_keep: assert property (
    sw_flags_wr |=> $stable(o_vm_mode))
    else $error("direct flags write changed mode flag");

  a_vm_set_cause: assert property (
    $rose(o_vm_mode) |-> $past(ts_go || stk_go))
    else $error("mode flag set outside switch or return");

  a_tss16_clears: assert property (
    (idle && i_ts_req && !i_ts.tss32) |=> !o_vm_mode)
    else $error("16-bit task image left mode flag set");

  a_ts_enter_vm: assert property (
    (idle && i_ts_req && i_ts.tss32 && i_ts.flags_img[`LTM_BIT_VM])
    |=> o_vm_mode)
    else $error("call or jump switch did not enter mode");

  a_interrupt_return_instr_nested: assert property (
    (idle && !i_ts_req && i_interrupt_return_instr_req && flags_r[`LTM_BIT_NT] &&
     i_ts.tss32 && i_ts.flags_img[`LTM_BIT_VM]) |=> o_vm_mode)
    else $error("nested return did not enter mode");

  a_interrupt_return_instr_stack: assert property (
    (stk_go && i_ts.flags_img[`LTM_BIT_VM]) |=> o_vm_mode)
    else $error("handler return did not enter mode");

  a_flags_first: assert property (
    (state_r == ltm_pkg::LTM_SEG) |=> $stable(flags_r))
    else $error("flags moved during segment loading");

  a_seq_length: assert property (
    $rose(o_busy) |-> o_busy [*6] ##1 !o_busy)
    else $error("segment load sequence not six cycles");

  a_legacy_base: assert property (
    (idle && vm && i_seg_load && !i_ts_req && !i_interrupt_return_instr_req &&
     i_seg_idx == 3'h0) |=> base_r[0] == {12'h000, $past(i_seg_sel), 4'h0})
    else $error("legacy base not selector shifted by four");

  a_cpl_user: assert property (
    (o_vm_mode && $past(o_vm_mode)) |-> o_cpl == `LTM_CPL_USER)
    else $error("privilege not 3 in emulation mode");

  a_page_deny: assert property (
    (i_page_chk && vm && !i_page_user) |=> o_page_deny)
    else $error("supervisor page reachable in emulation mode");

  a_linear_wide: assert property (
    (i_addr_req && vm && i_addr_seg == 3'h0) |=>
    o_linear_addr == $past(base_r[0]) + {16'h0000, $past(i_addr_off)})
    else $error("linear address wrapped or truncated");

  c_enter_call: cover property (
    (idle && i_ts_req && i_ts.tss32 && i_ts.flags_img[`LTM_BIT_VM])
    ##1 o_vm_mode);
  c_enter_stack: cover property (stk_go && i_ts.flags_img[`LTM_BIT_VM]);
  c_tss16: cover property (idle && i_ts_req && !i_ts.tss32);
  c_vm_seg_load: cover property (idle && vm && i_seg_load);

endmodule

// File: test/ltm_mode_ctrl_tb_top.sv
// Self-checking bench for the legacy task mode control
`timescale 1ns/1ps
`include "ltm_params.svh"

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end

module ltm_mode_ctrl_tb_top;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] dec;
    logic [1:0] pcpl;
    logic pchk;
    logic puser;
    logic [4:0] exp;
  } ltm_row_s;

  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] o_reg_rdata;
  logic i_ts_req = 1'b0;
  logic i_interrupt_return_instr_req = 1'b0;
  ltm_pkg::ltm_ts_s i_ts = '0;
  logic i_seg_load = 1'b0;
  ltm_pkg::ltm_seg_t i_seg_idx = 3'h0;
  logic [15:0] i_seg_sel = 16'h0;
  logic [31:0] i_seg_desc_base = 32'h0;
  logic i_addr_req = 1'b0;
  ltm_pkg::ltm_seg_t i_addr_seg = 3'h0;
  logic [15:0] i_addr_off = 16'h0;
  ltm_pkg::ltm_dec_s i_dec = '0;
  logic [1:0] i_prot_cpl = 2'h0;
  logic i_page_chk = 1'b0;
  logic i_page_user = 1'b0;
  logic o_vm_mode, o_busy, o_addr_valid, o_desc_lookup;
  logic [31:0] o_linear_addr;
  logic [1:0] o_cpl;
  logic o_dec_fault, o_io_privilege_level_sens, o_page_deny, o_seg_prot_en;
  int err_count = 0;
  int check_count = 0;
  ltm_row_s rows [4];

  always #12.5 i_clock = ~i_clock;

  ltm_mode_ctrl u_ltm_mode_ctrl (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_ts_req(i_ts_req),
    .i_interrupt_return_instr_req(i_interrupt_return_instr_req), .i_ts(i_ts), .i_seg_load(i_seg_load),
    .i_seg_idx(i_seg_idx), .i_seg_sel(i_seg_sel),
    .i_seg_desc_base(i_seg_desc_base), .i_addr_req(i_addr_req),
    .i_addr_seg(i_addr_seg), .i_addr_off(i_addr_off), .i_dec(i_dec),
    .i_prot_cpl(i_prot_cpl), .i_page_chk(i_page_chk),
    .i_page_user(i_page_user), .o_vm_mode(o_vm_mode), .o_busy(o_busy),
    .o_linear_addr(o_linear_addr), .o_addr_valid(o_addr_valid),
    .o_desc_lookup(o_desc_lookup), .o_cpl(o_cpl),
    .o_dec_fault(o_dec_fault), .o_io_privilege_level_sens(o_io_privilege_level_sens),
    .o_page_deny(o_page_deny), .o_seg_prot_en(o_seg_prot_en)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  // Checks one classification set, registered one cycle later
  task automatic chk_cls(input ltm_row_s r);
    @(posedge i_clock);
    i_dec <= r.dec;
    i_prot_cpl <= r.pcpl;
    i_page_chk <= r.pchk;
    i_page_user <= r.puser;
    @(posedge i_clock);
    #1;
    `CHK("cpl", r.exp[4:3], o_cpl);
    `CHK("dec_fault", r.exp[2], o_dec_fault);
    `CHK("io_privilege_level_sens", r.exp[1], o_io_privilege_level_sens);
    `CHK("page_deny", r.exp[0], o_page_deny);
  endtask

  // Switch or return; interrupt_return_instr selects the return path
  task automatic enter(input logic interrupt_return_instr, input logic t32,
                       input logic [31:0] fl, input logic ev);
    logic [31:0] d;
    logic [31:0] e;
    ltm_pkg::ltm_ts_s t;
    t = '0;
    t.tss32 = t32;
    t.flags_img = fl;
    for (int i = 0; i < 6; i++)
    begin
      t.sel[i] = 16'h1230 + 16'(i);
      t.desc_base[i] = 32'h00C00000 + 32'(i * 256);
    end
    @(posedge i_clock);
    i_ts <= t;
    i_ts_req <= ~interrupt_return_instr;
    i_interrupt_return_instr_req <= interrupt_return_instr;
    @(posedge i_clock);
    i_ts_req <= 1'b0;
    i_interrupt_return_instr_req <= 1'b0;
    #1;
    `CHK("vm_c1", ev, o_vm_mode);
    `CHK("busy_c1", 1'b1, o_busy);
    @(posedge i_clock);
    #1;
    `CHK("desc_c2", ~ev, o_desc_lookup);
    repeat (5) @(posedge i_clock);
    #1;
    `CHK("busy_c7", 1'b0, o_busy);
    for (int i = 0; i < 6; i++)
    begin
      reg_rd(`LTM_OFF_SEG0 + 8'(i * 4), d);
      e = ev ? {12'h000, 16'h1230 + 16'(i), 4'h0} :
               32'h00C00000 + 32'(i * 256);
      `CHK("seg", e, d);
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (4000) @(posedge i_clock);
    err_count++;
    give_verdict();
  end

  initial
  begin
    logic [31:0] d;
    rows[0] = {4'hC, 2'h0, 1'b1, 1'b0, 5'b00000};
    rows[1] = {4'hC, 2'h3, 1'b1, 1'b0, 5'b11101};
    rows[2] = {4'hB, 2'h0, 1'b0, 1'b0, 5'b00000};
    rows[3] = {4'h4, 2'h2, 1'b1, 1'b1, 5'b10000};
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    #1;
    `CHK("vm_rst", 1'b0, o_vm_mode);
    `CHK("prot_rst", 1'b1, o_seg_prot_en);
    reg_rd(`LTM_OFF_FLAGS, d);
    `CHK("flags_rst", 32'h00000002, d);
    reg_rd(8'hFC, d);
    `CHK("unmapped", 32'h00000000, d);
    foreach (rows[i])
      chk_cls(rows[i]);
    // Direct write never sets the mode flag
    reg_wr(`LTM_OFF_FLAGS, 32'h00023002);
    reg_rd(`LTM_OFF_FLAGS, d);
    `CHK("flags_wr", 32'h00003002, d);
    `CHK("vm_wr", 1'b0, o_vm_mode);
    // Call or jump switch into the mode
    enter(1'b0, 1'b1, 32'h00020002, 1'b1);
    `CHK("prot_vm", 1'b0, o_seg_prot_en);
    reg_rd(`LTM_OFF_STATUS, d);
    `CHK("status", 32'h0000000D, d);
    chk_cls({4'hB, 2'h0, 1'b1, 1'b0, 5'b11111});
    chk_cls({4'hC, 2'h0, 1'b1, 1'b1, 5'b11100});
    // Selector load and top-of-range address
    @(posedge i_clock);
    i_seg_load <= 1'b1;
    i_seg_idx <= 3'h0;
    i_seg_sel <= 16'hFFFF;
    i_seg_desc_base <= 32'h0BAD0000;
    @(posedge i_clock);
    i_seg_load <= 1'b0;
    i_addr_req <= 1'b1;
    i_addr_seg <= 3'h0;
    i_addr_off <= 16'hFFFF;
    #1;
    `CHK("desc_vm", 1'b0, o_desc_lookup);
    @(posedge i_clock);
    i_addr_req <= 1'b0;
    #1;
    `CHK("addr_valid", 1'b1, o_addr_valid);
    `CHK("linear", 32'h0010FFEF, o_linear_addr);
    // Clearing write keeps the flag
    reg_wr(`LTM_OFF_FLAGS, 32'h00000002);
    @(posedge i_clock);
    #1;
    `CHK("vm_keep", 1'b1, o_vm_mode);
    // Small image drops the upper flags word
    enter(1'b0, 1'b0, 32'h00020002, 1'b0);
    // Nested return runs a task switch
    reg_wr(`LTM_OFF_FLAGS, 32'h00004002);
    enter(1'b1, 1'b1, 32'h00020002, 1'b1);
    enter(1'b0, 1'b1, 32'h00000002, 1'b0);
    // Handler return from a stack image
    enter(1'b1, 1'b1, 32'h00020002, 1'b1);
    // Reset in mid-run drops the mode
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    #1;
    `CHK("vm_rst2", 1'b0, o_vm_mode);
    `CHK("busy_rst2", 1'b0, o_busy);
    `CHK("cpl_rst2", 2'h0, o_cpl);
    reg_rd(`LTM_OFF_FLAGS, d);
    `CHK("flags_rst2", 32'h00000002, d);
    give_verdict();
  end
endmodule
